// ===== dv/i2c_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// I2C host: SCL idles high, SDA open drain
module i2c_host_model (
	// Clock
	input wire logic sys_clk,
	// Bus
	output logic scl,
	output logic sda_pull,
	input wire logic sda_line
);
	localparam int HALF = 6;
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : tick
	// SDA moves two clocks after SCL falls so the synced fall is seen first
	task automatic bit_io(input logic b, output logic r);
		tick(2);
		sda_pull = ~b;
		tick(HALF - 2);
		scl = 1'b1;
		tick(HALF);
		r = sda_line;
		scl = 1'b0;
	endtask : bit_io
	task automatic start();
		tick(HALF);
		sda_pull = 1'b1;
		tick(HALF);
		scl = 1'b0;
	endtask : start
	task automatic stop();
		tick(2);
		sda_pull = 1'b1;
		tick(HALF - 2);
		scl = 1'b1;
		tick(HALF);
		sda_pull = 1'b0;
		tick(HALF);
	endtask : stop
	task automatic send(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, r);
		ack = ~r;
	endtask : send
	// Last byte of a read is refused by the host to end the transfer
	task automatic recv(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, d[i]);
		end
		bit_io(last, r);
	endtask : recv
endmodule : i2c_host_model
`default_nettype wire

// ===== dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "sensor_consts.svh"
module tb import sensor_pkg::*;;
	logic sys_clk, rst_b, scl, sda_pull, sda_out, sda_oe, acq_busy;
	logic coef_load_en;
	logic [5:0] coef_load_idx;
	logic [31:0] coef_load_data;
	logic [31:0] meas_p;
	wire sda_line;
	int err_count, cmp_count, cyc;
	// Arbitrary value
	localparam logic [31:0] DWG = 32'h0000_4321;
	localparam logic [31:0] PRES = 32'h4120_0000;
	localparam logic [31:0] PRES2 = 32'h4130_0000;
	localparam logic [31:0] TEMP = 32'h41C8_0000;
	localparam logic [31:0] TARE = 32'h4040_0000;
	localparam logic [31:0] DIMS = 32'h0102_0001;
	localparam logic [31:0] KB = 32'h3F80_0000;
	// Released SDA floats to the pull-up level
	assign sda_line = ~sda_pull & (sda_oe ? sda_out : 1'b1);
	pressure_sensor_regs #(.MS_CYC(20), .PWR_CYC(400), .ACQ_CYC(2000),
		.DRAWING_NUMBER(DWG)) pressure_sensor_regs_inst (
		.sys_clk(sys_clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda_line),
		.sda_out(sda_out), .sda_oe(sda_oe), .meas_pressure(meas_p),
		.meas_temp(TEMP), .acq_busy(acq_busy),
		.coefficient_dimensions(DIMS), .coef_load_en(coef_load_en),
		.coef_load_idx(coef_load_idx), .coef_load_data(coef_load_data));
	i2c_host_model i2c_host_model_inst (.sys_clk(sys_clk), .scl(scl),
		.sda_pull(sda_pull), .sda_line(sda_line));
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 90000) begin
			err_count++;
			$display("CHECK FAILED t=%0t timeout", $time);
			wrap_up();
		end
	end
	task automatic wrap_up();
		if (err_count == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : wrap_up
	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk32
	task automatic chk1(input logic got, input logic exp);
		chk32({31'h0, got}, {31'h0, exp});
	endtask : chk1
	task automatic put(input logic [7:0] d);
		logic a;
		i2c_host_model_inst.send(d, a);
		chk1(a, 1'b1);
	endtask : put
	task automatic reg_write(input logic [7:0] p, input logic [31:0] d);
		i2c_host_model_inst.start();
		put({`DEV_ADDR, 1'b0});
		put(p);
		for (int i = 3; i >= 0; i--) begin
			put(d[i*8 +: 8]);
		end
		i2c_host_model_inst.stop();
	endtask : reg_write
	task automatic expect_reg(input logic [7:0] p, input logic [31:0] e);
		logic [31:0] d;
		i2c_host_model_inst.start();
		put({`DEV_ADDR, 1'b0});
		put(p);
		i2c_host_model_inst.stop();
		i2c_host_model_inst.start();
		put({`DEV_ADDR, 1'b1});
		for (int i = 3; i >= 0; i--) begin
			i2c_host_model_inst.recv(i == 0, d[i*8 +: 8]);
		end
		i2c_host_model_inst.stop();
		chk32(d, e);
	endtask : expect_reg
	// Bounded wait for the acquire indicator to reach a level
	task automatic wait_busy(input logic lvl, input int lim);
		int n;
		n = 0;
		while (acq_busy !== lvl && n < lim) begin
			@(negedge sys_clk);
			n++;
		end
		chk1(acq_busy, lvl);
	endtask : wait_busy
	initial begin
		logic ack;
		rst_b = 1'b0;
		coef_load_en = 1'b0;
		coef_load_idx = 6'h00;
		coef_load_data = 32'h0000_0000;
		meas_p = PRES;
		repeat (12) @(negedge sys_clk);
		rst_b = 1'b1;
		// Coefficient store has no reset, so fill it during power-up
		for (int i = 0; i < 60; i++) begin
			coef_load_en = 1'b1;
			coef_load_idx = i[5:0];
			coef_load_data = KB | 32'(i);
			@(negedge sys_clk);
		end
		coef_load_en = 1'b0;
		i2c_host_model_inst.start();
		i2c_host_model_inst.send({`DEV_ADDR, 1'b0}, ack);
		chk1(ack, 1'b0);
		chk1(acq_busy, 1'b0);
		i2c_host_model_inst.stop();
		wait_busy(1'b1, 400);
		expect_reg(`REG_STATUS, 32'h0000_0000);
		chk1(acq_busy, 1'b1);
		wait_busy(1'b0, 2000);
		expect_reg(`REG_STATUS, 32'h0000_0001);
		chk1(acq_busy, 1'b0);
		expect_reg(`REG_PRESSURE, PRES);
		expect_reg(`REG_COMP_TEMP, TEMP);
		reg_write(`REG_DRAWING, ~DWG);
		expect_reg(`REG_DRAWING, DWG);
		reg_write(`REG_TARE, TARE);
		expect_reg(`REG_TARE, TARE);
		expect_reg(`REG_PRESSURE, PRES);
		reg_write(`REG_STATUS, 32'h0000_1000);
		expect_reg(`REG_PRESSURE, 32'h40E0_0000);
		expect_reg(`REG_PCOEF + 8'h05, KB | 32'h05);
		expect_reg(`REG_PCOEF + 8'h06, 32'h0000_0000);
		expect_reg(`REG_TCOEF + 8'h01, KB | 32'h1F);
		expect_reg(`REG_TCOEF + 8'h02, 32'h0000_0000);
		reg_write(`REG_PCOEF, 32'h0000_0000);
		expect_reg(`REG_PCOEF, KB);
		// New measurement only shows once the next acquisition ends
		meas_p = PRES2;
		reg_write(`REG_STATUS, 32'h0000_0001);
		wait_busy(1'b1, 40);
		expect_reg(`REG_STATUS, 32'h0000_0000);
		expect_reg(`REG_PRESSURE, PRES);
		wait_busy(1'b0, 2000);
		expect_reg(`REG_STATUS, 32'h0000_0001);
		expect_reg(`REG_PRESSURE, PRES2);
		expect_reg(`REG_DELAY, 32'h0000_0064);
		reg_write(`REG_DELAY, 32'h0000_0002);
		reg_write(`REG_STATUS, 32'h0000_0100);
		chk1(acq_busy, 1'b0);
		wait_busy(1'b1, 60);
		// Requests queue up, so standby lasts one cycle before reacquiring
		wait_busy(1'b0, 2100);
		expect_reg(`REG_PRESSURE, PRES2);
		expect_reg(`REG_STATUS, 32'h0000_0100);
		reg_write(`REG_STATUS, 32'h0000_0000);
		wrap_up();
	end
endmodule : tb
`default_nettype wire

// ===== hw/float_subtract.sv
`timescale 1ns/1ps
`default_nettype none
module float_subtract import sensor_pkg::*; (
	// Operands, single precision
	input wire logic [31:0] minuend,
	input wire logic [31:0] subtrahend,
	// Result
	output logic [31:0] difference
);
	// Truncating, flushes denormals; NaN and infinity not special-cased
	logic sa, sb, sr, swap;
	logic [7:0] ea, eb, el, es, d;
	logic [26:0] ml, ms, ms_sh, norm;
	logic [27:0] acc;
	logic [4:0] lz;
	logic [8:0] er;
	logic [22:0] frac;
	always_comb begin
		sa = minuend[31];
		sb = ~subtrahend[31];
		ea = minuend[30:23];
		eb = subtrahend[30:23];
		swap = subtrahend[30:0] > minuend[30:0];
		el = swap ? eb : ea;
		es = swap ? ea : eb;
		sr = swap ? sb : sa;
		ml = swap ? {eb != 8'h00, subtrahend[22:0], 3'h0}
			: {ea != 8'h00, minuend[22:0], 3'h0};
		ms = swap ? {ea != 8'h00, minuend[22:0], 3'h0}
			: {eb != 8'h00, subtrahend[22:0], 3'h0};
		d = el - es;
		ms_sh = (d > 8'h1A) ? 27'h0 : (ms >> d);
		if (sa == sb) begin
			acc = {1'b0, ml} + {1'b0, ms_sh};
		end else begin
			acc = {1'b0, ml} - {1'b0, ms_sh};
		end
		lz = 5'h00;
		for (int i = 0; i < 27; i++) begin
			if (acc[i]) begin
				lz = 5'(26 - i);
			end
		end
		norm = acc[26:0] << lz;
		if (acc[27]) begin
			er = {1'b0, el} + 9'h001;
			frac = acc[26:4];
		end else begin
			er = {1'b0, el} - {4'h0, lz};
			frac = norm[25:3];
		end
		if (acc == 28'h0 || el == 8'h00 || er[8] || er == 9'h000) begin
			difference = 32'h0000_0000;
		end else if (er[7:0] == 8'hFF) begin
			difference = {sr, 8'hFF, 23'h0};
		end else begin
			difference = {sr, er[7:0], frac};
		end
	end
endmodule : float_subtract
`default_nettype wire

// ===== hw/pressure_sensor_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "sensor_consts.svh"
module pressure_sensor_regs import sensor_pkg::*; #(
	parameter int MS_CYC = `MS_CYC,
	parameter int PWR_CYC = `PWR_CYC,
	parameter int ACQ_CYC = `ACQ_CYC,
	// Arbitrary value
	parameter logic [31:0] DRAWING_NUMBER = 32'h0000_1234
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// I2C pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Sensing datapath
	input wire logic [31:0] meas_pressure,
	input wire logic [31:0] meas_temp,
	output logic acq_busy,
	// Calibration store
	input wire logic [31:0] coefficient_dimensions,
	input wire logic coef_load_en,
	input wire logic [5:0] coef_load_idx,
	input wire logic [31:0] coef_load_data
);
	// ==========================================
	// State
	seq_state_t st_ff;
	i2c_phase_t ph_ff;
	logic [2:0] scl_s_ff, sda_s_ff;
	logic [3:0] bit_ff;
	logic [7:0] shift_ff, tx_ff, ptr_ff;
	logic [1:0] idx_ff, lane_ff;
	logic rw_ff, sda_oe_ff, sda_o_ff;
	logic [23:0] wdata_ff;
	logic [31:0] rd_word_ff, tare_val_ff, pres_res_ff, temp_res_ff;
	logic auto_ff, tare_ff, new_data_flag_ff, req_pend_ff, acq_busy_ff;
	logic [15:0] delay_ff;
	logic [10:0] period_ff, per_cnt_ff;
	logic [19:0] ms_cnt_ff, cnt_ff;
	logic [31:0] coef_mem [60];
	logic scl_rise, scl_fall, start_det, stop_det, byte_done, addr_hit;
	logic wr_stb, ld_word, status_wr, new_req, auto_tick, acq_done;
	logic [31:0] wr_word, rd_mux, tared, st_word;
	logic [7:0] rd_byte, pidx, tidx;
	logic [17:0] pcount, tcount;

	assign sda_out = sda_o_ff;
	assign sda_oe = sda_oe_ff;
	assign acq_busy = acq_busy_ff;

	// ==========================================
	// Pin synchronisers and bus events
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			scl_s_ff <= 3'h7;
			sda_s_ff <= 3'h7;
			sda_o_ff <= 1'b0;
		end else begin
			scl_s_ff <= {scl_s_ff[1:0], scl_in};
			sda_s_ff <= {sda_s_ff[1:0], sda_in};
			sda_o_ff <= 1'b0;
		end
	end
	assign scl_rise = scl_s_ff[1] & ~scl_s_ff[2];
	assign scl_fall = ~scl_s_ff[1] & scl_s_ff[2];
	assign start_det = scl_s_ff[1] & scl_s_ff[2] & sda_s_ff[2] & ~sda_s_ff[1];
	assign stop_det = scl_s_ff[1] & scl_s_ff[2] & ~sda_s_ff[2] & sda_s_ff[1];
	assign byte_done = ph_ff == I_RX && scl_fall && bit_ff == 4'h8;
	assign addr_hit = shift_ff[7:1] == `DEV_ADDR;
	assign wr_stb = byte_done && idx_ff == 2'h2 && lane_ff == 2'h3;
	assign wr_word = {wdata_ff, shift_ff};
	assign ld_word = (byte_done && idx_ff == 2'h0 && addr_hit && shift_ff[0])
		|| (ph_ff == I_TXACK && scl_rise && !sda_s_ff[1]
		&& lane_ff == 2'h3);

	always_comb begin
		case (lane_ff)
			2'h0: rd_byte = rd_word_ff[31:24];
			2'h1: rd_byte = rd_word_ff[23:16];
			2'h2: rd_byte = rd_word_ff[15:8];
			default: rd_byte = rd_word_ff[7:0];
		endcase
	end

	// ==========================================
	// I2C slave, words sent and taken MSB first
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ph_ff <= I_IDLE;
			bit_ff <= 4'h0;
			shift_ff <= 8'h00;
			tx_ff <= 8'h00;
			ptr_ff <= 8'h00;
			idx_ff <= 2'h0;
			lane_ff <= 2'h0;
			rw_ff <= 1'b0;
			wdata_ff <= 24'h0;
			sda_oe_ff <= 1'b0;
		end else if (st_ff == S_PWR || stop_det) begin
			ph_ff <= I_IDLE;
			sda_oe_ff <= 1'b0;
		end else if (start_det) begin
			ph_ff <= I_RX;
			bit_ff <= 4'h0;
			idx_ff <= 2'h0;
			lane_ff <= 2'h0;
			sda_oe_ff <= 1'b0;
		end else begin
			case (ph_ff)
				I_RX: begin
					if (scl_rise && bit_ff != 4'h8) begin
						shift_ff <= {shift_ff[6:0], sda_s_ff[1]};
						bit_ff <= bit_ff + 4'h1;
					end else if (byte_done) begin
						ph_ff <= I_ACK;
						sda_oe_ff <= 1'b1;
						if (idx_ff == 2'h0) begin
							rw_ff <= shift_ff[0];
							idx_ff <= 2'h1;
							if (!addr_hit) begin
								ph_ff <= I_IDLE;
								sda_oe_ff <= 1'b0;
							end
						end else if (idx_ff == 2'h1) begin
							ptr_ff <= shift_ff;
							idx_ff <= 2'h2;
						end else begin
							wdata_ff <= {wdata_ff[15:0], shift_ff};
							lane_ff <= lane_ff + 2'h1;
							if (lane_ff == 2'h3) begin
								ptr_ff <= ptr_ff + 8'h01;
							end
						end
					end
				end
				I_ACK: begin
					if (scl_fall) begin
						bit_ff <= 4'h0;
						if (rw_ff) begin
							ph_ff <= I_TX;
							sda_oe_ff <= ~rd_byte[7];
							tx_ff <= {rd_byte[6:0], 1'b0};
						end else begin
							ph_ff <= I_RX;
							sda_oe_ff <= 1'b0;
						end
					end
				end
				I_TX: begin
					if (scl_fall) begin
						if (bit_ff == 4'h7) begin
							ph_ff <= I_TXACK;
							sda_oe_ff <= 1'b0;
							if (lane_ff == 2'h3) begin
								ptr_ff <= ptr_ff + 8'h01;
							end
						end else begin
							sda_oe_ff <= ~tx_ff[7];
							tx_ff <= {tx_ff[6:0], 1'b0};
							bit_ff <= bit_ff + 4'h1;
						end
					end
				end
				I_TXACK: begin
					if (scl_rise) begin
						if (sda_s_ff[1]) begin
							ph_ff <= I_IDLE;
						end else begin
							lane_ff <= lane_ff + 2'h1;
						end
					end else if (scl_fall) begin
						ph_ff <= I_TX;
						bit_ff <= 4'h0;
						sda_oe_ff <= ~rd_byte[7];
						tx_ff <= {rd_byte[6:0], 1'b0};
					end
				end
				default: ph_ff <= I_IDLE;
			endcase
		end
	end

	// ==========================================
	// Read side
	float_subtract u_tare_sub (
		.minuend(pres_res_ff),
		.subtrahend(tare_val_ff),
		.difference(tared)
	);
	assign pidx = ptr_ff - `REG_PCOEF;
	assign tidx = ptr_ff - `REG_TCOEF;
	assign pcount = 18'({9'h0, coefficient_dimensions[`DIM_PP]} + 18'h1)
		* 18'({9'h0, coefficient_dimensions[`DIM_PT]} + 18'h1);
	assign tcount = 18'({9'h0, coefficient_dimensions[`DIM_TP]} + 18'h1)
		* 18'({9'h0, coefficient_dimensions[`DIM_TT]} + 18'h1);

	always_comb begin
		st_word = 32'h0000_0000;
		st_word[`ST_FLAG] = new_data_flag_ff;
		st_word[`ST_AUTO] = auto_ff;
		st_word[`ST_TARE] = tare_ff;
		rd_mux = 32'h0000_0000;
		case (ptr_ff)
			`REG_STATUS: rd_mux = st_word;
			`REG_PRESSURE: rd_mux = tare_ff ? tared : pres_res_ff;
			`REG_COMP_TEMP: rd_mux = temp_res_ff;
			`REG_DIMS: rd_mux = coefficient_dimensions;
			`REG_DELAY: rd_mux = {16'h0000, delay_ff};
			`REG_DRAWING: rd_mux = DRAWING_NUMBER;
			`REG_TARE: rd_mux = tare_val_ff;
			default: begin
				// Entries past the fitted count read as zero
				if (pidx < `COEF_SLOTS && {10'h0, pidx} < pcount) begin
					rd_mux = coef_mem[pidx[5:0]];
				end else if (tidx < `COEF_SLOTS && {10'h0, tidx} < tcount) begin
					rd_mux = coef_mem[6'(tidx + `COEF_SLOTS)];
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_word_ff <= 32'h0000_0000;
		end else if (ld_word) begin
			rd_word_ff <= rd_mux;
		end
	end

	// Only the calibration store fills the coefficients
	always_ff @(posedge sys_clk) begin
		if (coef_load_en) begin
			coef_mem[coef_load_idx] <= coef_load_data;
		end
	end

	// ==========================================
	// Host-written controls
	assign status_wr = wr_stb && ptr_ff == `REG_STATUS;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			auto_ff <= 1'b0;
			tare_ff <= 1'b0;
			delay_ff <= `DELAY_RST;
			tare_val_ff <= 32'h0000_0000;
		end else if (wr_stb) begin
			if (ptr_ff == `REG_STATUS) begin
				auto_ff <= wr_word[`ST_AUTO];
				tare_ff <= wr_word[`ST_TARE];
			end
			if (ptr_ff == `REG_DELAY) begin
				delay_ff <= wr_word[15:0];
			end
			if (ptr_ff == `REG_TARE) begin
				tare_val_ff <= wr_word;
			end
		end
	end

	// ==========================================
	// Auto-update timer; delay taken when auto mode is entered
	assign auto_tick = auto_ff && ms_cnt_ff == 20'(MS_CYC - 1)
		&& per_cnt_ff + 11'h001 >= period_ff;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ms_cnt_ff <= 20'h0;
			per_cnt_ff <= 11'h000;
			period_ff <= 11'h000;
		end else if (!auto_ff) begin
			ms_cnt_ff <= 20'h0;
			per_cnt_ff <= 11'h000;
			period_ff <= 11'(delay_ff % `DELAY_MOD);
		end else if (ms_cnt_ff == 20'(MS_CYC - 1)) begin
			ms_cnt_ff <= 20'h0;
			per_cnt_ff <= auto_tick ? 11'h000 : per_cnt_ff + 11'h001;
		end else begin
			ms_cnt_ff <= ms_cnt_ff + 20'h1;
		end
	end

	// ==========================================
	// Operating state sequencer
	assign acq_done = st_ff == S_ACQ && cnt_ff == 20'(ACQ_CYC - 1);
	assign new_req = (status_wr && wr_word[`ST_FLAG]) || auto_tick;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_ff <= S_PWR;
			cnt_ff <= 20'h0;
			acq_busy_ff <= 1'b0;
			pres_res_ff <= 32'h0000_0000;
			temp_res_ff <= 32'h0000_0000;
		end else begin
			case (st_ff)
				S_PWR: begin
					if (cnt_ff == 20'(PWR_CYC - 1)) begin
						st_ff <= S_ACQ;
						cnt_ff <= 20'h0;
						acq_busy_ff <= 1'b1;
					end else begin
						cnt_ff <= cnt_ff + 20'h1;
					end
				end
				S_ACQ: begin
					if (acq_done) begin
						st_ff <= S_STBY;
						acq_busy_ff <= 1'b0;
						pres_res_ff <= meas_pressure;
						temp_res_ff <= meas_temp;
					end else begin
						cnt_ff <= cnt_ff + 20'h1;
					end
				end
				S_STBY: begin
					if (req_pend_ff) begin
						st_ff <= S_ACQ;
						cnt_ff <= 20'h0;
						acq_busy_ff <= 1'b1;
					end
				end
				default: st_ff <= S_PWR;
			endcase
		end
	end

	// Set wins over clear for both flags
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			req_pend_ff <= 1'b0;
			new_data_flag_ff <= 1'b0;
		end else begin
			req_pend_ff <= new_req || (req_pend_ff && st_ff != S_STBY);
			if (acq_done) begin
				new_data_flag_ff <= 1'b1;
			end else if (status_wr || (ld_word && auto_ff
				&& (ptr_ff == `REG_PRESSURE || ptr_ff == `REG_COMP_TEMP))) begin
				new_data_flag_ff <= 1'b0;
			end
		end
	end

	// ==========================================
	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	sequence s_host_req;
		status_wr && wr_word[`ST_FLAG] && !acq_done;
	endsequence
	sequence s_reacquire;
		!new_data_flag_ff ##1 st_ff == S_ACQ;
	endsequence
	property p_drawing;
		ld_word && ptr_ff == `REG_DRAWING |=> rd_word_ff == DRAWING_NUMBER;
	endproperty
	a_drawing: assert property (p_drawing) else $error("drawing wrong");
	property p_tare;
		ld_word && ptr_ff == `REG_PRESSURE |=> rd_word_ff ==
			($past(tare_ff) ? $past(tared) : $past(pres_res_ff));
	endproperty
	a_tare: assert property (p_tare) else $error("tare wrong");
	property p_pcoef_zero;
		ld_word && pidx < `COEF_SLOTS && {10'h0, pidx} >= pcount
			|=> rd_word_ff == 32'h0000_0000;
	endproperty
	a_pcoef_zero: assert property (p_pcoef_zero) else $error("coef");
	property p_pwr_quiet;
		st_ff == S_PWR |-> !sda_oe_ff && ph_ff == I_IDLE;
	endproperty
	a_pwr_quiet: assert property (p_pwr_quiet) else $error("bus active");
	property p_pwr_exit;
		st_ff == S_PWR && cnt_ff == 20'(PWR_CYC - 1)
			|=> st_ff == S_ACQ && acq_busy_ff;
	endproperty
	a_pwr_exit: assert property (p_pwr_exit) else $error("no acquire");
	property p_hold;
		st_ff == S_ACQ && !acq_done |=> $stable(pres_res_ff);
	endproperty
	a_hold: assert property (p_hold) else $error("early result");
	property p_done;
		acq_done |=> st_ff == S_STBY && new_data_flag_ff && !acq_busy_ff
			&& pres_res_ff == $past(meas_pressure);
	endproperty
	a_done: assert property (p_done) else $error("no standby");
	property p_stay;
		st_ff == S_STBY && !req_pend_ff |=> st_ff == S_STBY;
	endproperty
	a_stay: assert property (p_stay) else $error("left standby");
	property p_restart;
		st_ff == S_STBY && req_pend_ff |=> st_ff == S_ACQ && cnt_ff == 20'h0;
	endproperty
	a_restart: assert property (p_restart) else $error("no restart");
	property p_manual;
		s_host_req and st_ff == S_STBY |=> s_reacquire;
	endproperty
	a_manual: assert property (p_manual) else $error("manual req");
	property p_auto;
		auto_tick && !req_pend_ff |=> req_pend_ff || st_ff == S_ACQ;
	endproperty
	a_auto: assert property (p_auto) else $error("auto req lost");
endmodule : pressure_sensor_regs
`default_nettype wire

// ===== hw/sensor_consts.svh
`ifndef SENSOR_CONSTS_SVH
`define SENSOR_CONSTS_SVH
// ==========================================
// Register pointers and coefficient slot count
`define REG_STATUS 8'h00
`define REG_PRESSURE 8'h01
`define REG_COMP_TEMP 8'h02
`define REG_DIMS 8'h43
`define REG_DELAY 8'h55
`define REG_DRAWING 8'h56
`define REG_TARE 8'h57
`define REG_PCOEF 8'h80
`define REG_TCOEF 8'h9E
`define COEF_SLOTS 8'h1E
// ==========================================
// Status fields
`define ST_FLAG 0
`define ST_AUTO 8
`define ST_TARE 12
// ==========================================
// Fit order fields of coefficient_dimensions
`define DIM_PP 31:24
`define DIM_PT 23:16
`define DIM_TP 15:8
`define DIM_TT 7:0
// ==========================================
// Reset values, delay modulus and bus address
`define DELAY_RST 16'h0064
`define DELAY_MOD 16'h07D0
`define DEV_ADDR 7'h02
// ==========================================
// Timing
`define CLK_PERIOD_NS 50
`define MS_NS 1000000
`define PWR_TIME_US 1000
`define ACQ_TIME_US 2000
`define MS_CYC (`MS_NS / `CLK_PERIOD_NS)
`define PWR_CYC ((`PWR_TIME_US * 1000) / `CLK_PERIOD_NS)
`define ACQ_CYC ((`ACQ_TIME_US * 1000) / `CLK_PERIOD_NS)
`endif

// ===== hw/sensor_pkg.sv
package sensor_pkg;
	// ==========================================
	// Operating states and bus phases
	typedef enum logic [1:0] {S_PWR, S_ACQ, S_STBY} seq_state_t;
	typedef enum logic [2:0] {I_IDLE, I_RX, I_ACK, I_TX, I_TXACK} i2c_phase_t;
endpackage : sensor_pkg
